// *** rtl/adc_sequencer.sv ***
// successive-approximation conversion sequencer with an APB register file
// Function
// - nonzero acquisition: sample then auto-convert
// - acquisition codes give 0,2,4,6,8,12,16,20 periods
// - manual mode converts as start is set
// - acquisition select resets to zero
// - completion clears start, sets done, resamples
// - no status splits acquisition from conversion
// - conversion lasts eleven bit periods, the first one partial on the rc clock
// - clock select picks divider or rc clock
// - manual with rc clock delays one cycle
// - clearing start aborts running conversion
// - abort leaves result registers untouched
// - two bit periods wait, then resample
// - sampling switch opens at conversion start
// - analog pins read as zero on port
// - channel and direction never gate sequencing
// - pin config resets by analog fuse
// - reset turns converter off, aborts
`timescale 1ns/1ps
module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int pin_count = 13
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_analog_reset_fuse,
  input wire logic internal_rc_conv_clock,
  input wire logic [pin_count-1:0] port_pins,
  input wire logic comparator_out,
  output logic sample_switch_closed,
  output logic [3:0] channel_select,
  output logic trial_bit_valid,
  output logic [result_width-1:0] trial_code,
  output logic conversion_done_flag
);
  if (pin_count < 1 || pin_count > 16)
  begin : g_pin_count_check
    $error("pin_count must lie between 1 and 16");
  end

  logic converter_on;
  logic go;
  logic [3:0] pin_analog_cfg;
  logic [2:0] acq_time_sel;
  logic [2:0] conv_clock_sel;
  logic [result_width-1:0] result;
  logic [result_width-1:0] sar;
  logic [4:0] count;
  seq_state_type state;
  logic fuse_sync1, fuse_sync2;
  logic [1:0] fuse_age;
  logic rc_sync1, rc_sync2, rc_prev;
  logic [pin_count-1:0] pin_sync1, pin_sync2;
  logic tick;

  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    unique case (code)
      3'h0: acq_periods = 5'd0;
      3'h1: acq_periods = 5'd2;
      3'h2: acq_periods = 5'd4;
      3'h3: acq_periods = 5'd6;
      3'h4: acq_periods = 5'd8;
      3'h5: acq_periods = 5'd12;
      3'h6: acq_periods = 5'd16;
      3'h7: acq_periods = 5'd20;
    endcase
  endfunction

  // bus decode
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire hit_ctrl = (paddr == ctrl_addr);
  wire hit_timing = (paddr == timing_addr);
  wire hit_result = (paddr == result_addr);
  wire hit_status = (paddr == status_addr);
  wire hit_port = (paddr == port_addr);
  wire mapped = hit_ctrl | hit_timing | hit_result | hit_status | hit_port;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_status = wr && hit_status;
  // clearing go or converter_on stops a sequence; a write of zero while acquiring or converting aborts
  wire sw_go = pwdata[go_bit];
  wire rc_sel = (conv_clock_sel[1:0] == 2'b11);
  wire rc_edge = rc_sync2 && !rc_prev;
  wire busy = (state == st_delay) || (state == st_acquire) ||
              (state == st_convert);
  wire abort = wr_ctrl && !sw_go && (state == st_convert);
  wire last_bit = (state == st_convert) && tick && !abort &&
                  (count == conv_bit_periods - 5'd1);
  // comparator answers the registered trial code within the cycle, so it is
  // read directly: two sync flops would outlast the shortest bit period
  logic [result_width-1:0] sar_next;
  always_comb
  begin
    sar_next = sar;
    if (count != 5'd0 && count <= 5'(result_width))
      sar_next[result_width - 32'(count)] = comparator_out;
  end
  // port read masks analog pins; cfg n of 3 or more leaves pins below 15-n
  // analog, smaller codes all thirteen, so 4'hf leaves none
  logic [15:0] analog_mask;
  always_comb
  begin
    analog_mask = 16'h0000;
    for (int i = 0; i < 16; i++)
      analog_mask[i] = (i < 13) &&
        (pin_analog_cfg < 4'h3 || i < 15 - int'(pin_analog_cfg));
  end
  wire [15:0] port_read = 16'(pin_sync2) & ~analog_mask;
  // go stays visible through acquire and convert alike
  wire [31:0] ctrl_word = {20'h0, pin_analog_cfg, 2'b00, channel_select,
                           go, converter_on};
  wire [31:0] read_mux =
    hit_ctrl ? ctrl_word :
    hit_timing ? {26'h0, acq_time_sel, conv_clock_sel} :
    hit_result ? {22'h0, result} :
    hit_status ? {31'h0, conversion_done_flag} :
    hit_port ? {16'h0, port_read} : 32'h0;

  bit_period_tick u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .run((busy || state == st_settle) && !abort),
    .conv_clock_sel(conv_clock_sel),
    .rc_clock_edge(rc_edge),
    .tick(tick)
  );

  // synchronisers for pins and the rc clock
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {fuse_sync1, fuse_sync2, rc_sync1, rc_sync2, rc_prev} <= 5'h00;
      pin_sync1 <= '0;
      pin_sync2 <= '0;
    end
    else
    begin
      fuse_sync1 <= port_analog_reset_fuse;
      fuse_sync2 <= fuse_sync1;
      rc_sync1 <= internal_rc_conv_clock;
      rc_sync2 <= rc_sync1;
      rc_prev <= rc_sync2;
      pin_sync1 <= port_pins;
      pin_sync2 <= pin_sync1;
    end

  // bus slave: zero wait states, error on unmapped addresses
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup && !pwrite ? read_mux : 32'h0;
    end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      converter_on <= 1'b0;
      channel_select <= 4'h0;
      pin_analog_cfg <= pin_cfg_reset_fuse1;
      fuse_age <= 2'h0;
      acq_time_sel <= acq_time_sel_reset;
      conv_clock_sel <= conv_clock_sel_reset;
    end
    else
    begin
      // fuse is taken once the second sync stage holds the pin value;
      // a software write before then wins and cancels the load
      if (wr_ctrl)
      begin
        fuse_age <= 2'h3;
        pin_analog_cfg <= pwdata[pin_analog_cfg_lsb +: 4];
      end
      else if (fuse_age != 2'h3)
      begin
        fuse_age <= fuse_age + 2'h1;
        if (fuse_age == 2'h2)
          pin_analog_cfg <= fuse_sync2 ? pin_cfg_reset_fuse1
                                       : pin_cfg_reset_fuse0;
      end
      if (wr_ctrl)
      begin
        converter_on <= pwdata[converter_on_bit];
        channel_select <= pwdata[channel_select_lsb +: 4];
      end
      if (wr && hit_timing)
      begin
        acq_time_sel <= pwdata[acq_time_sel_lsb +: 3];
        conv_clock_sel <= pwdata[conv_clock_sel_lsb +: 3];
      end
    end

  // sequencer; channel and direction bits never enter it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state <= st_sample;
      go <= 1'b0;
      count <= 5'd0;
      sar <= '0;
      sample_switch_closed <= 1'b0;
      trial_bit_valid <= 1'b0;
      trial_code <= '0;
      conversion_done_flag <= 1'b0;
      result <= '0;
    end
    else
    begin
      trial_bit_valid <= 1'b0;
      sample_switch_closed <= converter_on &&
        (state == st_sample || state == st_acquire || state == st_delay);
      if (last_bit)
        conversion_done_flag <= 1'b1;
      else if (wr_status && pwdata[done_flag_bit])
        conversion_done_flag <= 1'b0;
      if (wr && hit_result && state != st_convert)
        result <= pwdata[result_width-1:0];
      unique case (state)
        st_sample:
          if (wr_ctrl && sw_go && converter_on)
          begin
            go <= 1'b1;
            count <= 5'd0;
            if (acq_time_sel != 3'h0)
              state <= st_acquire;
            else if (rc_sel)
              state <= st_delay;
            else
            begin
              state <= st_convert;
              sample_switch_closed <= 1'b0;
              sar <= '0;
            end
          end
        st_delay:
        begin
          state <= st_convert;
          sample_switch_closed <= 1'b0;
          sar <= '0;
        end
        st_acquire:
          if (wr_ctrl && !sw_go)
          begin
            go <= 1'b0;
            state <= st_sample;
          end
          else if (tick && count == acq_periods(acq_time_sel) - 5'd1)
          begin
            count <= 5'd0;
            state <= st_convert;
            sample_switch_closed <= 1'b0;
            sar <= '0;
          end
          else if (tick)
            count <= count + 5'd1;
        st_convert:
          if (abort)
          begin
            go <= 1'b0;
            count <= 5'd0;
            state <= st_settle;
          end
          else if (tick)
          begin
            // first period settles, then one bit per period, msb first
            sar <= sar_next;
            if (count != 5'd0)
              trial_bit_valid <= 1'b1;
            if (count < 5'(result_width))
              trial_code <= sar_next | (result_width'(1) <<
                            (result_width - 1 - 32'(count)));
            if (last_bit)
            begin
              result <= sar_next;
              go <= 1'b0;
              count <= 5'd0;
              state <= st_settle;
            end
            else
              count <= count + 5'd1;
          end
        st_settle:
          if (tick && count == settle_bit_periods - 5'd1)
            state <= st_sample;
          else if (tick)
            count <= count + 5'd1;
      endcase
      if (wr_ctrl && !pwdata[converter_on_bit] && state != st_settle)
      begin
        go <= 1'b0;
        state <= st_sample;
      end
    end

  property p_conv_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(state == st_convert) && !wr_ctrl |-> !last_bit;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion ended on its first cycle");

  property p_done_clears_go;
    @(posedge pclk) disable iff (!presetn)
      last_bit |=> !go && conversion_done_flag && state == st_settle;
  endproperty
  a_done_clears_go: assert property (p_done_clears_go)
    else $error("completion did not clear start and set done");

  property p_abort_keeps;
    @(posedge pclk) disable iff (!presetn)
      abort |=> $stable(result) && !go;
  endproperty
  a_abort_keeps: assert property (p_abort_keeps)
    else $error("abort changed result");

  property p_switch_open;
    @(posedge pclk) disable iff (!presetn)
      state == st_convert |-> !sample_switch_closed;
  endproperty
  a_switch_open: assert property (p_switch_open)
    else $error("switch closed while converting");

  property p_go_visible;
    @(posedge pclk) disable iff (!presetn)
      (state == st_acquire || state == st_convert) |-> go;
  endproperty
  a_go_visible: assert property (p_go_visible)
    else $error("start bit dropped during sequence");

  property p_manual;
    @(posedge pclk) disable iff (!presetn)
      state == st_sample && wr_ctrl && sw_go && converter_on &&
      acq_time_sel == 3'h0 && !rc_sel |=> state == st_convert;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual start did not convert at once");

  property p_rc_delay;
    @(posedge pclk) disable iff (!presetn)
      state == st_sample && wr_ctrl && sw_go && converter_on &&
      acq_time_sel == 3'h0 && rc_sel |=> state == st_delay ##1
      state == st_convert;
  endproperty
  a_rc_delay: assert property (p_rc_delay)
    else $error("rc manual start not delayed one cycle");

  property p_settle;
    @(posedge pclk) disable iff (!presetn)
      state == st_settle && tick && count == 5'd1 |=> state == st_sample;
  endproperty
  a_settle: assert property (p_settle)
    else $error("settle wait not two periods");
endmodule

// *** rtl/adc_seq_pkg.sv ***
// constants shared by the conversion sequencer and its bit-period prescaler
package adc_seq_pkg;
  // register byte addresses
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] timing_addr = 12'h004;
  localparam logic [11:0] result_addr = 12'h008;
  localparam logic [11:0] status_addr = 12'h00c;
  localparam logic [11:0] port_addr = 12'h010;
  // control register fields
  localparam int converter_on_bit = 0;
  localparam int go_bit = 1;
  localparam int channel_select_lsb = 2;
  localparam int pin_analog_cfg_lsb = 8;
  // timing register fields
  localparam int conv_clock_sel_lsb = 0;
  localparam int acq_time_sel_lsb = 3;
  // status register fields
  localparam int done_flag_bit = 0;
  localparam int sampling_bit = 1;
  // reset values
  localparam logic [2:0] acq_time_sel_reset = 3'h0;
  localparam logic [2:0] conv_clock_sel_reset = 3'h0;
  localparam logic [3:0] pin_cfg_reset_fuse1 = 4'h0;
  localparam logic [3:0] pin_cfg_reset_fuse0 = 4'h7;
  // timing counts in bit periods, and the result width in bits
  localparam logic [4:0] conv_bit_periods = 5'd11;
  localparam logic [4:0] settle_bit_periods = 5'd2;
  localparam int result_width = 10;
  typedef enum logic [2:0] {
    st_sample, st_delay, st_acquire, st_convert, st_settle
  } seq_state_type;
endpackage

// *** rtl/bit_period_tick.sv ***
// prescaler that turns the selected clock source into a bit-period tick
`timescale 1ns/1ps
module bit_period_tick
  import adc_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] conv_clock_sel,
  input wire logic rc_clock_edge,
  output logic tick
);
  logic [5:0] count;
  logic [5:0] limit;
  wire use_rc = (conv_clock_sel[1:0] == 2'b11);
  // divide by 2 << {sel[1:0],sel[2]}: 000=2 100=4 001=8 101=16 010=32 110=64
  assign limit = 6'(((7'd2) << {conv_clock_sel[1:0], conv_clock_sel[2]}) - 7'd1);
  wire wrap = (count == limit);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      count <= 6'h00;
      tick <= 1'b0;
    end
    else
    begin
      // dropping run restarts the divider period, so a wait on the divider always spans whole ticks
      count <= (!run || wrap || use_rc) ? 6'h00 : count + 6'h01;
      tick <= run && (use_rc ? rc_clock_edge : wrap);
    end
endmodule

// *** tb/sar_analog_model.sv ***
// behavioural hold capacitor and comparator facing the sequencer
`timescale 1ns/1ps
module sar_analog_model
  import adc_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic sample_switch_closed,
  input wire logic [result_width-1:0] trial_code,
  input wire logic [result_width-1:0] analog_level,
  output logic comparator_out
);
  logic [result_width-1:0] held = '0;
  // cap tracks the pin only while the switch is closed, so a late level
  // change during conversion cannot leak into the result
  always @(posedge pclk)
  begin
    if (sample_switch_closed)
      held <= analog_level;
  end
  assign comparator_out = (held >= trial_code);
endmodule

// *** tb/tb_adc_acquisition_conversion_sequencer.sv ***
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_adc_acquisition_conversion_sequencer;
  import adc_seq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, fuse, rc_clk, comp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, rd, saved;
  logic pready, pslverr, err, switch_closed, trial_valid, done_flag;
  logic [12:0] pins;
  logic [3:0] chan_out;
  logic [result_width-1:0] trial, level;
  int num_errors, n_checks, cyc, t_go, e, n;
  int n_trial = 0;
  int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int div_tab[8] = '{2, 8, 32, 0, 4, 16, 64, 0};

  adc_sequencer adc_sequencer_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_analog_reset_fuse(fuse), .internal_rc_conv_clock(rc_clk),
    .port_pins(pins), .comparator_out(comp),
    .sample_switch_closed(switch_closed), .channel_select(chan_out),
    .trial_bit_valid(trial_valid), .trial_code(trial),
    .conversion_done_flag(done_flag));
  sar_analog_model sar_analog_model_inst (.pclk(pclk),
    .sample_switch_closed(switch_closed), .trial_code(trial),
    .analog_level(level), .comparator_out(comp));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // rc source deliberately unrelated to pclk
  initial
  begin
    rc_clk = 1'b0;
    forever #35 rc_clk = ~rc_clk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (trial_valid)
      n_trial <= n_trial + 1;
    if (cyc == 40000)
    begin
      num_errors++;
      complete_run();
    end
  end

  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function logic [31:0] ctrl_word(input logic [3:0] cfg,
      input logic [3:0] ch, input logic go, input logic on);
    return {20'h0, cfg, 2'b00, ch, go, on};
  endfunction
  function logic [12:0] port_exp(input logic [3:0] cfg,
      input logic [12:0] p);
    logic [12:0] m;
    for (int i = 0; i < 13; i++)
      m[i] = (cfg < 3) || (cfg != 4'hf && i < 15 - cfg);
    return p & ~m;
  endfunction

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    t_go = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task check_range(input string what, input int lo, input int hi,
      input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi,
        got);
      num_errors++;
    end
  endtask
  task end_test(input string name);
    $display("test %s done", name);
  endtask
  task wait_switch(output int cnt);
    cnt = 0;
    while (switch_closed !== 1'b1 && cnt < 3000)
    begin
      @(posedge pclk);
      cnt++;
    end
  endtask
  task convert(input logic [2:0] ck, input logic [2:0] aq,
      output int el);
    int d, s, t0;
    d = div_tab[ck];
    t0 = n_trial;
    rnd = lfsr(rnd);
    level <= rnd[9:0];
    apb(1'b1, timing_addr, {26'h0, aq, ck});
    apb(1'b1, ctrl_addr,
      ctrl_word(4'hf, rnd[13:10], 1'b0, 1'b1));
    apb(1'b1, ctrl_addr,
      ctrl_word(4'hf, rnd[13:10], 1'b1, 1'b1));
    check("channel", rnd[13:10], chan_out);
    el = t_go;
    while (done_flag !== 1'b1 && cyc - el < 3000)
      @(posedge pclk);
    el = cyc - el;
    check("switch at done", 1'b0, switch_closed);
    wait_switch(s);
    if (d > 0)
      check_range("settle", 2 * d - 2, 2 * d + 4, s);
    check("trial bits", 10, n_trial - t0);
    apb(1'b0, result_addr, 0);
    check("result", rnd[9:0], rd[9:0]);
    apb(1'b0, ctrl_addr, 0);
    check("start cleared", 1'b0, rd[go_bit]);
    apb(1'b0, status_addr, 0);
    check("done status", 1'b1, rd[done_flag_bit]);
    apb(1'b1, status_addr, 32'h1 << done_flag_bit);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pins, level} = '0;
    num_errors = 0;
    n_checks = 0;
    cyc = 0;
    fuse = 1'b1;
    rnd = 32'h3391af23;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, ctrl_addr, 0);
    check("ctrl reset", 32'h0, rd);
    apb(1'b0, timing_addr, 0);
    check("acq select reset", acq_time_sel_reset, rd[5:3]);
    apb(1'b0, 12'h0fc, 0);
    check("unmapped error", 1'b1, err);
    end_test("reset");
    for (int c = 0; c < 8; c++)
    begin
      convert(3'b000, c[2:0], e);
      check_range("acq conv", (acq_tab[c] + 10) * 2,
        (acq_tab[c] + 11) * 2 + 6, e);
    end
    end_test("acquisition");
    for (int k = 0; k < 8; k++)
    begin
      convert(k[2:0], 3'b000, e);
      if (div_tab[k] > 0)
        check_range("conv time", 10 * div_tab[k],
          11 * div_tab[k] + 6, e);
    end
    end_test("clock select");
    rnd = lfsr(rnd);
    saved = {22'h0, rnd[9:0]};
    apb(1'b1, result_addr, saved);
    apb(1'b1, timing_addr, 32'h6);
    apb(1'b1, ctrl_addr, ctrl_word(4'hf, 4'h2, 1'b0, 1'b1));
    apb(1'b1, ctrl_addr, ctrl_word(4'hf, 4'h2, 1'b1, 1'b1));
    repeat (200) @(posedge pclk);
    check("switch in conv", 1'b0, switch_closed);
    apb(1'b1, ctrl_addr, ctrl_word(4'hf, 4'h2, 1'b0, 1'b1));
    wait_switch(n);
    check_range("abort settle", 2 * 64 - 2, 2 * 64 + 6, n);
    repeat (900) @(posedge pclk);
    check("no done on abort", 1'b0, done_flag);
    apb(1'b0, result_addr, 0);
    check("result kept", saved, {22'h0, rd[9:0]});
    end_test("abort");
    for (int k = 0; k < 16; k++)
    begin
      rnd = lfsr(rnd);
      pins <= rnd[12:0];
      apb(1'b1, ctrl_addr, ctrl_word(k[3:0], 4'h0, 1'b0, 1'b0));
      repeat (4) @(posedge pclk);
      apb(1'b0, port_addr, 0);
      check("port", port_exp(k[3:0], rnd[12:0]), rd[12:0]);
    end
    end_test("port");
    fuse <= 1'b0;
    apb(1'b1, ctrl_addr, ctrl_word(4'hf, 4'h1, 1'b0, 1'b1));
    apb(1'b1, ctrl_addr, ctrl_word(4'hf, 4'h1, 1'b1, 1'b1));
    repeat (50) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("switch in reset", 1'b0, switch_closed);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, ctrl_addr, 0);
    check("ctrl after reset",
      {20'h0, pin_cfg_reset_fuse0, 8'h0}, rd);
    end_test("reset in conversion");
    complete_run();
  end
endmodule
